// file: design/carrier_sense_and_level_freeze.sv
module carrier_sense_and_level_freeze (
   input wire logic I_REF_CLK,
   input wire logic I_RST_N,
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [7:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   input wire logic I_SAMPLE_VALID,
   input wire logic I_SAMPLE_AT_OR_ABOVE,
   input wire logic I_GAIN_CHANGE,
   input wire logic I_FREQ_SWITCH,
   input wire logic I_PLL_UNLOCK,
   input wire logic I_RX_POWER_UP,
   output logic O_PREADY,
   output logic [31:0] O_PRDATA,
   output logic O_PSLVERR,
   output logic O_LOCK,
   output logic O_LEVELS_FROZEN,
   output logic O_IRQ
);
   cs_freeze_pkg::apb_req_t req;
   cs_freeze_pkg::cfg_t cfg;
   logic [7:0] config_r;
   logic [7:0] config_nxt;
   logic [2:0] decimation_divisor_r;
   logic [2:0] decimation_divisor_nxt;
   logic [2:0] int_r;
   logic [2:0] int_nxt;
   logic [2:0] mask_r;
   logic [2:0] mask_nxt;
   logic irq_r;
   logic irq_nxt;
   logic pready_r;
   logic pready_nxt;
   logic slverr_r;
   logic slverr_nxt;
   logic [31:0] prdata_r;
   logic [31:0] prdata_nxt;
   logic access;
   logic commit;
   logic wr_int;
   logic cs;
   logic cs_d_r;
   logic [2:0] events;
   logic [cs_freeze_pkg::DIV_W-1:0] filt_period;
   logic filt_tick;
   logic adc_tick;
   logic trig;
   cs_freeze_pkg::freeze_state_t state_r;
   cs_freeze_pkg::freeze_state_t state_nxt;
   logic [7:0] cnt_r;
   logic [7:0] cnt_nxt;
   logic pend_r;
   logic pend_nxt;
   logic frozen_r;
   logic frozen_nxt;
   logic frz_end;
   logic hold_forever;

   assign req = '{sel: I_PSEL, enable: I_PENABLE, write: I_PWRITE,
                  addr: I_PADDR, wdata: I_PWDATA};
   assign cfg = cs_freeze_pkg::cfg_t'(config_r);
   assign access = req.sel && req.enable;
   assign commit = access && pready_r;
   assign trig = I_FREQ_SWITCH || I_PLL_UNLOCK || I_RX_POWER_UP;
   assign hold_forever = (cfg.wait_code == cs_freeze_pkg::WAIT_FOREVER);
   assign wr_int = commit && req.write && !slverr_r
                   && req.addr == cs_freeze_pkg::OFS_INT_STATUS;

   // Filter clock period scales with the decimation divisor.
   assign filt_period = 12'(cs_freeze_pkg::FILT_TICK_BASE_CYC
                            * (32'(decimation_divisor_r) + 1));

   rate_divider u_filt_div (
      .i_clk(I_REF_CLK),
      .i_rst_n(I_RST_N),
      .i_period(filt_period),
      .o_tick(filt_tick)
   );

   rate_divider u_adc_div (
      .i_clk(I_REF_CLK),
      .i_rst_n(I_RST_N),
      .i_period(12'(cs_freeze_pkg::ADC_TICK_CYC)),
      .o_tick(adc_tick)
   );

   cs_qualifier u_cs (
      .i_clk(I_REF_CLK),
      .i_rst_n(I_RST_N),
      .i_sample_valid(I_SAMPLE_VALID),
      .i_at_or_above(I_SAMPLE_AT_OR_ABOVE),
      .i_assert_code(cfg.assert_code),
      .i_release_two(cfg.release_two),
      .o_cs(cs)
   );

   // Bus slave: one wait state, then the answer stands for one cycle.
   always_comb begin
      pready_nxt = access && !pready_r;
      slverr_nxt = slverr_r;
      prdata_nxt = prdata_r;
      config_nxt = config_r;
      decimation_divisor_nxt = decimation_divisor_r;
      mask_nxt = mask_r;
      if (access && !pready_r) begin
         slverr_nxt = 1'b0;
         prdata_nxt = 32'h0000_0000;
         if (req.addr == cs_freeze_pkg::OFS_CONFIG) begin
            prdata_nxt[7:0] = config_r;
         end else if (req.addr == cs_freeze_pkg::OFS_FILTER) begin
            prdata_nxt[2:0] = decimation_divisor_r;
         end else if (req.addr == cs_freeze_pkg::OFS_STATUS) begin
            prdata_nxt[cs_freeze_pkg::STAT_CS] = cs;
            prdata_nxt[cs_freeze_pkg::STAT_FROZEN] = frozen_r;
         end else if (req.addr == cs_freeze_pkg::OFS_INT_STATUS) begin
            prdata_nxt[2:0] = int_r;
         end else if (req.addr == cs_freeze_pkg::OFS_INT_MASK) begin
            prdata_nxt[2:0] = mask_r;
         end else begin
            slverr_nxt = 1'b1;
         end
      end
      if (commit && req.write && !slverr_r) begin
         if (req.addr == cs_freeze_pkg::OFS_CONFIG) begin
            config_nxt = req.wdata[7:0];
         end else if (req.addr == cs_freeze_pkg::OFS_FILTER) begin
            decimation_divisor_nxt = req.wdata[2:0];
         end else if (req.addr == cs_freeze_pkg::OFS_INT_MASK) begin
            mask_nxt = req.wdata[2:0];
         end
      end
      events = 3'h0;
      events[cs_freeze_pkg::INT_CS_SET] = cs && !cs_d_r;
      events[cs_freeze_pkg::INT_CS_CLR] = !cs && cs_d_r;
      events[cs_freeze_pkg::INT_FRZ_END] = frz_end;
      int_nxt = (int_r & ~(wr_int ? req.wdata[2:0] : 3'h0)) | events;
      irq_nxt = |(int_nxt & mask_nxt);
   end

   always_ff @(posedge I_REF_CLK) begin
      if (!I_RST_N) begin
         pready_r <= 1'b0;
         slverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
         config_r <= cs_freeze_pkg::CONFIG_RST;
         decimation_divisor_r <= cs_freeze_pkg::DECIMATION_DIVISOR_RST;
         mask_r <= cs_freeze_pkg::INT_RST;
         int_r <= cs_freeze_pkg::INT_RST;
         irq_r <= 1'b0;
         cs_d_r <= 1'b0;
      end else begin
         pready_r <= pready_nxt;
         slverr_r <= slverr_nxt;
         prdata_r <= prdata_nxt;
         config_r <= config_nxt;
         decimation_divisor_r <= decimation_divisor_nxt;
         mask_r <= mask_nxt;
         int_r <= int_nxt;
         irq_r <= irq_nxt;
         cs_d_r <= cs;
      end
   end

   // Freeze timer: gain-change hold, then the extra hold when one is pending.
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      pend_nxt = pend_r || trig;
      frz_end = 1'b0;
      case (state_r)
         cs_freeze_pkg::FRZ_IDLE: begin
            if (I_GAIN_CHANGE) begin
               state_nxt = cs_freeze_pkg::FRZ_WAIT;
               cnt_nxt = cs_freeze_pkg::wait_len(cfg.wait_code);
            end else if (pend_r) begin
               state_nxt = cs_freeze_pkg::FRZ_EXTRA;
               cnt_nxt = cs_freeze_pkg::extra_len(cfg.extra_code);
               pend_nxt = trig;
            end
         end
         cs_freeze_pkg::FRZ_WAIT: begin
            if (I_GAIN_CHANGE) begin
               cnt_nxt = cs_freeze_pkg::wait_len(cfg.wait_code);
            end else if (filt_tick && !hold_forever) begin
               if (cnt_r <= 8'h01) begin
                  state_nxt = cs_freeze_pkg::FRZ_IDLE;
                  cnt_nxt = 8'h00;
                  frz_end = !pend_r;
                  // A pending extra hold follows at once, so the levels never thaw between.
                  if (pend_r) begin
                     state_nxt = cs_freeze_pkg::FRZ_EXTRA;
                     cnt_nxt = cs_freeze_pkg::extra_len(cfg.extra_code);
                     pend_nxt = trig;
                  end
               end else begin
                  cnt_nxt = cnt_r - 8'h01;
               end
            end
         end
         cs_freeze_pkg::FRZ_EXTRA: begin
            if (I_GAIN_CHANGE) begin
               state_nxt = cs_freeze_pkg::FRZ_WAIT;
               cnt_nxt = cs_freeze_pkg::wait_len(cfg.wait_code);
            end else if (adc_tick) begin
               if (cnt_r <= 8'h01) begin
                  state_nxt = cs_freeze_pkg::FRZ_IDLE;
                  cnt_nxt = 8'h00;
                  frz_end = !pend_r;
               end else begin
                  cnt_nxt = cnt_r - 8'h01;
               end
            end
         end
         default: begin
            state_nxt = cs_freeze_pkg::FRZ_IDLE;
         end
      endcase
      frozen_nxt = (state_nxt != cs_freeze_pkg::FRZ_IDLE) || hold_forever;
   end

   always_ff @(posedge I_REF_CLK) begin
      if (!I_RST_N) begin
         state_r <= cs_freeze_pkg::FRZ_IDLE;
         cnt_r <= 8'h00;
         pend_r <= 1'b0;
         frozen_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         pend_r <= pend_nxt;
         frozen_r <= frozen_nxt;
      end
   end

   assign O_PREADY = pready_r;
   assign O_PRDATA = prdata_r;
   assign O_PSLVERR = slverr_r;
   assign O_LOCK = cs;
   assign O_LEVELS_FROZEN = frozen_r;
   assign O_IRQ = irq_r;

   // Helper counters that only the checks below read.
   logic [7:0] h_wait_r;
   logic [7:0] h_extra_r;
   logic [cs_freeze_pkg::DIV_W-1:0] h_gap_r;
   logic h_gap_ok_r;

   always_ff @(posedge I_REF_CLK) begin
      if (!I_RST_N) begin
         h_wait_r <= 8'h00;
         h_extra_r <= 8'h00;
         h_gap_r <= 12'h000;
         h_gap_ok_r <= 1'b0;
      end else begin
         if (state_r != cs_freeze_pkg::FRZ_WAIT || I_GAIN_CHANGE) begin
            h_wait_r <= 8'h00;
         end else if (filt_tick && !hold_forever) begin
            h_wait_r <= h_wait_r + 8'h01;
         end
         if (state_r != cs_freeze_pkg::FRZ_EXTRA) begin
            h_extra_r <= 8'h00;
         end else if (adc_tick) begin
            h_extra_r <= h_extra_r + 8'h01;
         end
         h_gap_r <= filt_tick ? 12'h000 : h_gap_r + 12'h001;
         if (commit && req.write && req.addr == cs_freeze_pkg::OFS_FILTER) begin
            h_gap_ok_r <= 1'b0;
         end else if (filt_tick) begin
            h_gap_ok_r <= 1'b1;
         end
      end
   end

   a_gain_hold_start: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      I_GAIN_CHANGE |=> state_r == cs_freeze_pkg::FRZ_WAIT && O_LEVELS_FROZEN)
      else $error("Gain change did not start the freeze.");

   a_gain_hold_len: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      $past(state_r) == cs_freeze_pkg::FRZ_WAIT && state_r != cs_freeze_pkg::FRZ_WAIT
      |-> h_wait_r == cs_freeze_pkg::wait_len($past(cfg.wait_code)))
      else $error("Gain-change freeze had the wrong number of filter clocks.");

   a_hold_forever: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      hold_forever |=> O_LEVELS_FROZEN
      && (state_r == cs_freeze_pkg::FRZ_WAIT || $past(state_r) != cs_freeze_pkg::FRZ_WAIT))
      else $error("Levels not frozen with the unconditional hold code.");

   a_extra_pending: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      trig |=> pend_r)
      else $error("Extra freeze was not scheduled after a trigger event.");

   a_extra_after_wait: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      state_r == cs_freeze_pkg::FRZ_IDLE && pend_r && !I_GAIN_CHANGE
      |=> state_r == cs_freeze_pkg::FRZ_EXTRA && O_LEVELS_FROZEN)
      else $error("Pending extra freeze did not start.");

   a_extra_len: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      $past(state_r) == cs_freeze_pkg::FRZ_EXTRA && state_r == cs_freeze_pkg::FRZ_IDLE
      |-> h_extra_r == cs_freeze_pkg::extra_len($past(cfg.extra_code)))
      else $error("Extra freeze had the wrong number of converter clocks.");

   a_filter_rate: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      filt_tick && h_gap_ok_r |-> h_gap_r == filt_period - 12'h001)
      else $error("Filter clock spacing does not match the divisor.");

   a_irq_level: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      ##1 O_IRQ == |(int_r & mask_r))
      else $error("Interrupt output disagrees with status and mask.");

   c_wait_done: cover property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      state_r == cs_freeze_pkg::FRZ_WAIT ##1 state_r == cs_freeze_pkg::FRZ_EXTRA);
   c_extra_done: cover property (@(posedge I_REF_CLK) disable iff (!I_RST_N) frz_end);
   c_irq: cover property (@(posedge I_REF_CLK) disable iff (!I_RST_N) $rose(O_IRQ));
endmodule : carrier_sense_and_level_freeze

// file: design/cs_freeze_pkg.sv
package cs_freeze_pkg;
   localparam int unsigned CLK_HZ = 250_000_000;
   localparam int unsigned FILT_BASE_HZ = 307_200;
   localparam int unsigned FILT_TICK_BASE_CYC = CLK_HZ / (2 * FILT_BASE_HZ);
   localparam int unsigned ADC_CLK_HZ = 1_228_800;
   localparam int unsigned ADC_TICK_CYC = CLK_HZ / ADC_CLK_HZ;
   localparam int DIV_W = 12;
   localparam logic [7:0] OFS_CONFIG = 8'h00;
   localparam logic [7:0] OFS_FILTER = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_INT_STATUS = 8'h0c;
   localparam logic [7:0] OFS_INT_MASK = 8'h10;
   localparam logic [7:0] CONFIG_RST = 8'h65;
   localparam logic [2:0] DECIMATION_DIVISOR_RST = 3'h0;
   localparam int INT_W = 3;
   localparam logic [INT_W-1:0] INT_RST = 3'h0;
   localparam int INT_CS_SET = 0;
   localparam int INT_CS_CLR = 1;
   localparam int INT_FRZ_END = 2;
   localparam int STAT_CS = 0;
   localparam int STAT_FROZEN = 1;
   localparam logic [2:0] WAIT_FOREVER = 3'h7;
   localparam logic [7:0] EXTRA_BASE = 8'h10;
   localparam logic [2:0] RUN_MAX = 3'h4;

   typedef enum logic [1:0] {FRZ_IDLE, FRZ_WAIT, FRZ_EXTRA} freeze_state_t;

   typedef struct packed {
      logic sel;
      logic enable;
      logic write;
      logic [7:0] addr;
      logic [31:0] wdata;
   } apb_req_t;

   typedef struct packed {
      logic [1:0] assert_code;
      logic release_two;
      logic [2:0] wait_code;
      logic [1:0] extra_code;
   } cfg_t;

   function automatic logic [7:0] wait_len(input logic [2:0] code);
      case (code)
         3'h0: wait_len = 8'h10;
         3'h1: wait_len = 8'h14;
         3'h2: wait_len = 8'h18;
         3'h3: wait_len = 8'h1c;
         3'h4: wait_len = 8'h20;
         3'h5: wait_len = 8'h28;
         3'h6: wait_len = 8'h30;
         default: wait_len = 8'h00;
      endcase
   endfunction : wait_len

   function automatic logic [7:0] extra_len(input logic [1:0] code);
      extra_len = EXTRA_BASE << code;
   endfunction : extra_len

   function automatic logic [2:0] sat_inc(input logic [2:0] v);
      sat_inc = (v >= RUN_MAX) ? RUN_MAX : 3'(v + 3'h1);
   endfunction : sat_inc
endpackage : cs_freeze_pkg

// file: design/rate_divider.sv
module rate_divider (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [cs_freeze_pkg::DIV_W-1:0] i_period,
   output logic o_tick
);
   logic [cs_freeze_pkg::DIV_W-1:0] cnt_r;
   logic [cs_freeze_pkg::DIV_W-1:0] cnt_nxt;
   logic tick_r;
   logic tick_nxt;

   // Emits one pulse every i_period cycles.
   always_comb begin
      cnt_nxt = cnt_r + 12'h001;
      tick_nxt = 1'b0;
      if (cnt_r >= i_period - 12'h001) begin
         cnt_nxt = 12'h000;
         tick_nxt = 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         cnt_r <= 12'h000;
         tick_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign o_tick = tick_r;
endmodule : rate_divider

// file: design/cs_qualifier.sv
module cs_qualifier (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_sample_valid,
   input wire logic i_at_or_above,
   input wire logic [1:0] i_assert_code,
   input wire logic i_release_two,
   output logic o_cs
);
   logic [2:0] above_cnt_r;
   logic [2:0] above_cnt_nxt;
   logic [2:0] below_cnt_r;
   logic [2:0] below_cnt_nxt;
   logic cs_r;
   logic cs_nxt;
   logic [2:0] need_above;
   logic [2:0] need_below;

   always_comb begin
      need_above = {1'b0, i_assert_code} + 3'h1;
      need_below = i_release_two ? 3'h2 : 3'h1;
      above_cnt_nxt = above_cnt_r;
      below_cnt_nxt = below_cnt_r;
      cs_nxt = cs_r;
      if (i_sample_valid && i_at_or_above) begin
         above_cnt_nxt = cs_freeze_pkg::sat_inc(above_cnt_r);
         below_cnt_nxt = 3'h0;
         if (above_cnt_nxt >= need_above) begin
            cs_nxt = 1'b1;
         end
      end else if (i_sample_valid) begin
         above_cnt_nxt = 3'h0;
         below_cnt_nxt = cs_freeze_pkg::sat_inc(below_cnt_r);
         if (below_cnt_nxt >= need_below) begin
            cs_nxt = 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         above_cnt_r <= 3'h0;
         below_cnt_r <= 3'h0;
         cs_r <= 1'b0;
      end else begin
         above_cnt_r <= above_cnt_nxt;
         below_cnt_r <= below_cnt_nxt;
         cs_r <= cs_nxt;
      end
   end

   assign o_cs = cs_r;

   a_cs_set_run: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      $rose(cs_r) |-> $past(i_sample_valid && i_at_or_above) && above_cnt_r >= $past(need_above))
      else $error("Carrier sense set before enough samples.");

   a_run_restart: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_sample_valid |=> ($past(i_at_or_above) ? below_cnt_r : above_cnt_r) == 3'h0)
      else $error("Sample counters did not restart on a crossing.");

   a_cs_release: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      cs_r && i_sample_valid && !i_at_or_above && i_release_two && below_cnt_r == 3'h0
      |=> cs_r)
      else $error("Carrier sense cleared after one sample with two required.");

   a_cs_clear_run: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      $fell(cs_r) |-> below_cnt_r >= $past(need_below))
      else $error("Carrier sense cleared before enough samples.");

   c_cs_set: cover property (@(posedge i_clk) disable iff (!i_rst_n) $rose(cs_r));
   c_cs_clear: cover property (@(posedge i_clk) disable iff (!i_rst_n) $fell(cs_r));
endmodule : cs_qualifier

// file: verif/cs_source.sv
module cs_source (
   input wire logic i_clk,
   input wire logic i_req,
   input wire logic i_level,
   output logic o_valid,
   output logic o_above
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_valid = 1'b0;
      o_above = 1'b0;
   end
   // Between samples the level line means nothing, so it toggles every cycle.
   always @(posedge i_clk) begin
      o_valid <= i_req;
      o_above <= i_req ? i_level : ~o_above;
   end
endmodule : cs_source

// file: verif/carrier_sense_and_level_freeze_tb.sv
module carrier_sense_and_level_freeze_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, psel, penable, pwrite, req, level, gain, fsw, unlock, pwrup;
   logic [7:0] paddr;
   logic [31:0] pwdata, q, prdata;
   logic e, valid, above, pready, pslverr, lock, frozen, irq;
   int mismatches, checks_done, cycles, len, g;
   int codes[2] = '{0, 6};
   int ticks[7] = '{16, 20, 24, 28, 32, 40, 48};

   cs_source u_src (.i_clk(clk), .i_req(req), .i_level(level), .o_valid(valid),
      .o_above(above));
   carrier_sense_and_level_freeze u_dut (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel),
      .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
      .I_SAMPLE_VALID(valid), .I_SAMPLE_AT_OR_ABOVE(above), .I_GAIN_CHANGE(gain),
      .I_FREQ_SWITCH(fsw), .I_PLL_UNLOCK(unlock), .I_RX_POWER_UP(pwrup), .O_PREADY(pready),
      .O_PRDATA(prdata), .O_PSLVERR(pslverr), .O_LOCK(lock), .O_LEVELS_FROZEN(frozen),
      .O_IRQ(irq));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 100000) begin
         mismatches++;
         conclude();
      end
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : conclude

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : check

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(q, exp, "register read");
   endtask : rd

   function automatic logic [31:0] cfg(input logic [1:0] a, input logic r, input logic [2:0] h,
      input logic [1:0] x);
      cfg = {24'h0, a, r, h, x};
   endfunction : cfg

   task automatic send(input logic lvl, input int k);
      for (int i = 0; i < k; i++) begin
         @(posedge clk);
         req <= 1'b1;
         level <= lvl;
         @(posedge clk);
         req <= 1'b0;
      end
      repeat (3) @(posedge clk);
      @(negedge clk);
   endtask : send

   task automatic freeze(input logic [3:0] v, input int lo, input int hi);
      @(posedge clk);
      {gain, fsw, unlock, pwrup} <= v;
      @(posedge clk);
      {gain, fsw, unlock, pwrup} <= 4'h0;
      repeat (2) @(negedge clk);
      len = 0;
      while (frozen === 1'b1 && len < 60000) begin
         @(negedge clk);
         len++;
      end
      check({31'h0, len >= lo && len <= hi}, 32'h1, "freeze length");
   endtask : freeze

   initial begin
      {rst_n, psel, penable, pwrite, req, level, gain, fsw, unlock, pwrup} = 10'h000;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rd(cs_freeze_pkg::OFS_CONFIG, {24'h0, cs_freeze_pkg::CONFIG_RST});
      rd(cs_freeze_pkg::OFS_FILTER, 32'h0);
      rd(cs_freeze_pkg::OFS_STATUS, 32'h0);
      rd(cs_freeze_pkg::OFS_INT_STATUS, 32'h0);
      rd(cs_freeze_pkg::OFS_INT_MASK, 32'h0);
      apb(1'b1, 8'h14, 32'h5);
      check({31'h0, e}, 32'h1, "unmapped write error");
      rd(8'h14, 32'h0);
      check({31'h0, e}, 32'h1, "unmapped read error");
      $display("test reset done");
      apb(1'b1, cs_freeze_pkg::OFS_INT_MASK, 32'h1);
      for (int c = 0; c < 4; c++) begin
         apb(1'b1, cs_freeze_pkg::OFS_CONFIG, cfg(2'(c), 1'b0, 3'h0, 2'h0));
         send(1'b1, c);
         check({31'h0, lock}, 32'h0, "lock early");
         send(1'b1, 1);
         check({31'h0, lock}, 32'h1, "lock set");
         send(1'b0, 1);
         check({31'h0, lock}, 32'h0, "lock clear one");
      end
      check({31'h0, irq}, 32'h1, "irq raised");
      rd(cs_freeze_pkg::OFS_INT_STATUS, 32'h3);
      apb(1'b1, cs_freeze_pkg::OFS_INT_STATUS, 32'h1);
      @(negedge clk);
      check({31'h0, irq}, 32'h0, "irq cleared");
      rd(cs_freeze_pkg::OFS_INT_STATUS, 32'h2);
      $display("test assert counts done");
      apb(1'b1, cs_freeze_pkg::OFS_CONFIG, cfg(2'h3, 1'b1, 3'h0, 2'h0));
      send(1'b1, 3);
      send(1'b0, 1);
      send(1'b1, 3);
      check({31'h0, lock}, 32'h0, "run restarted");
      send(1'b1, 1);
      rd(cs_freeze_pkg::OFS_STATUS, 32'h1);
      send(1'b0, 1);
      check({31'h0, lock}, 32'h1, "one below kept");
      send(1'b1, 1);
      send(1'b0, 1);
      check({31'h0, lock}, 32'h1, "below run restarted");
      send(1'b0, 1);
      check({31'h0, lock}, 32'h0, "two below clear");
      $display("test restart done");
      apb(1'b1, cs_freeze_pkg::OFS_INT_STATUS, 32'h7);
      foreach (codes[i]) begin
         apb(1'b1, cs_freeze_pkg::OFS_CONFIG, cfg(2'h1, 1'b1, 3'(codes[i]), 2'h0));
         freeze(4'h8, (ticks[codes[i]] - 1) * 406 - 4, ticks[codes[i]] * 406 + 4);
      end
      rd(cs_freeze_pkg::OFS_INT_STATUS, 32'h4);
      apb(1'b1, cs_freeze_pkg::OFS_FILTER, 32'h1);
      apb(1'b1, cs_freeze_pkg::OFS_CONFIG, cfg(2'h1, 1'b1, 3'h0, 2'h0));
      freeze(4'h8, 15 * 812 - 4, 16 * 812 + 4);
      apb(1'b1, cs_freeze_pkg::OFS_FILTER, 32'h0);
      for (int x = 0; x < 3; x++) begin
         apb(1'b1, cs_freeze_pkg::OFS_CONFIG, cfg(2'h1, 1'b1, 3'h0, 2'(x)));
         g = (x == 1) ? 0 : 406;
         freeze((x == 1) ? 4'h2 : 4'h8 | (4'h4 >> x), 15 * g + ((16 << x) - 1) * 203 - 4,
            16 * g + (16 << x) * 203 + 8);
      end
      $display("test freeze done");
      apb(1'b1, cs_freeze_pkg::OFS_CONFIG, cfg(2'h1, 1'b1, 3'h7, 2'h0));
      @(posedge clk);
      gain <= 1'b1;
      @(posedge clk);
      gain <= 1'b0;
      repeat (3000) @(negedge clk);
      check({31'h0, frozen}, 32'h1, "frozen indefinitely");
      $display("test hold forever done");
      conclude();
   end
endmodule : carrier_sense_and_level_freeze_tb
